// *** design/hall_motor_commutator_consts.vh ***
// constants for the hall commutator: register offsets, field codes, defaults
// assumes inclusion by bare name from the design directory
`ifndef HALL_MOTOR_COMMUTATOR_CONSTS_VH
`define HALL_MOTOR_COMMUTATOR_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_POLES     12'h008
`define OFS_AMPL      12'h00C
`define OFS_HOME_SEL  12'h010
`define OFS_SEQ_BASE  12'h020
`define OFS_SEQ_LAST  12'h03C

// ****************************************************************
// control fields
// ****************************************************************
`define CTRL_SINE     0
`define CTRL_PH60     1
`define CTRL_ENC_MNT  2
`define CTRL_ENABLE   3

// ****************************************************************
// phase command codes, 2 bits per phase
// ****************************************************************
`define PH_OFF        2'h0
`define PH_HIGH       2'h1
`define PH_LOW        2'h2

// six-bit table entry {c,b,a}
`define E_AH_CL       6'h21
`define E_BH_CL       6'h24
`define E_BH_AL       6'h06
`define E_CH_AL       6'h12
`define E_CH_BL       6'h18
`define E_AH_BL       6'h09
`define E_NONE        6'h00

// hall codes with no valid entry for each phasing
`define INV60_A       3'h5
`define INV60_B       3'h2
`define INV120_A      3'h7
`define INV120_B      3'h0

`define CTRL_RST      4'h0
`define POLES_RST     8'h04
`define AMPL_RST      16'h4000
`define HOME_RST      2'h0

`define ENC_BITS      16
`define ANG_BITS      10
`define ANG_THIRD     10'h155
`define ANG_2THIRD    10'h2AB

`endif

// *** design/hall_motor_commutator.v ***
// hall/encoder commutation with an apb register file
// assumes synchronous encoder and homing inputs on pclk; hall is synchronised here
`timescale 1ns/1ps
`include "hall_motor_commutator_consts.vh"

module hall_motor_commutator (
  input  wire        pclk,        // system clock
  input  wire        presetn,     // async reset, low active
  input  wire        psel,        // apb select
  input  wire        penable,     // apb enable
  input  wire        pwrite,      // apb direction
  input  wire [11:0] paddr,       // apb byte address
  input  wire [31:0] pwdata,      // apb write data
  output reg  [31:0] prdata,      // apb read data
  output reg         pready,      // apb ready
  output reg         pslverr,     // apb error
  input  wire [2:0]  hall_in,     // {h1,h2,h3}
  input  wire [15:0] enc_pos,     // mechanical position, full turn = 2^16
  input  wire        limit_sw,    // limit switch
  input  wire        home_sw,     // home switch
  input  wire        enc_index,   // encoder index pulse
  output reg  [1:0]  phase_a_ff,  // phase a command off/high/low
  output reg  [1:0]  phase_b_ff,  // phase b command
  output reg  [1:0]  phase_c_ff,  // phase c command
  output reg  [15:0] sin_a_ff,    // signed phase a current command
  output reg  [15:0] sin_b_ff,    // signed phase b current command
  output reg  [15:0] sin_c_ff,    // signed phase c current command
  output reg         home_ref_ff  // selected homing reference
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [3:0]  ctrl_ff;
  reg [7:0]  poles_ff;
  reg [15:0] ampl_ff;
  reg [1:0]  home_sel_ff;
  reg [5:0]  seq_ff [0:7];
  reg [2:0]  hall_s1_ff;
  reg [2:0]  hall_s2_ff;
  reg [2:0]  hall_ff;

  wire       wr_en  = psel & penable & pwrite & pready;
  wire       acc    = psel & ~penable;
  wire       in_seq = (paddr >= `OFS_SEQ_BASE) && (paddr <= `OFS_SEQ_LAST);
  wire [2:0] seq_ix = paddr[4:2];
  // sine only honoured when encoder is motor mounted
  wire       sine_on = ctrl_ff[`CTRL_SINE] & ctrl_ff[`CTRL_ENC_MNT];

  // ****************************************************************
  // default table: index is hall code, 60 and 120 share one array
  // ****************************************************************
  function [5:0] dflt;
    input       ph60;
    input [2:0] code;
    begin
      case (code)
        3'b100: dflt = `E_AH_CL;
        3'b110: dflt = `E_BH_CL;
        3'b011: dflt = `E_CH_AL;
        3'b001: dflt = `E_CH_BL;
        3'b010: dflt = ph60 ? `E_NONE : `E_BH_AL;
        3'b101: dflt = ph60 ? `E_NONE : `E_AH_BL;
        3'b111: dflt = ph60 ? `E_BH_AL : `E_NONE;
        3'b000: dflt = ph60 ? `E_AH_BL : `E_NONE;
        default: dflt = `E_NONE;
      endcase
    end
  endfunction

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        prdata <= 32'h0000_0000;
        if (in_seq)
          prdata <= {26'h000_0000, seq_ff[seq_ix]};
        else begin
          case (paddr)
            `OFS_CTRL:     prdata <= {28'h000_0000, ctrl_ff};
            `OFS_STATUS:   prdata <= {21'h0_0000, home_ref_ff, phase_c_ff,
                                      phase_b_ff, phase_a_ff, hall_ff,
                                      sine_on};
            `OFS_POLES:    prdata <= {24'h00_0000, poles_ff};
            `OFS_AMPL:     prdata <= {16'h0000, ampl_ff};
            `OFS_HOME_SEL: prdata <= {30'h0000_0000, home_sel_ff};
            default:       pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // switching phasing reloads defaults, keeping table consistent
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_seq
      localparam [2:0] entry_ix = gi;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          seq_ff[gi] <= dflt(1'b0, entry_ix);
        else if (wr_en && in_seq && seq_ix == entry_ix)
          seq_ff[gi] <= pwdata[5:0];
        else if (wr_en && paddr == `OFS_CTRL &&
                 pwdata[`CTRL_PH60] != ctrl_ff[`CTRL_PH60])
          seq_ff[gi] <= dflt(pwdata[`CTRL_PH60], entry_ix);
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= `CTRL_RST;
      poles_ff    <= `POLES_RST;
      ampl_ff     <= `AMPL_RST;
      home_sel_ff <= `HOME_RST;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL:     ctrl_ff     <= pwdata[3:0];
        `OFS_POLES:    poles_ff    <= pwdata[7:0];
        `OFS_AMPL:     ampl_ff     <= pwdata[15:0];
        `OFS_HOME_SEL: home_sel_ff <= pwdata[1:0];
        default:       ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  // ****************************************************************
  // hall synchroniser and trapezoid output
  // ****************************************************************
  wire [5:0] entry = seq_ff[hall_ff];
  // table entries are user data, so invalid codes are gated here too
  wire       bad_code = ctrl_ff[`CTRL_PH60] ?
                        (hall_ff == `INV60_A || hall_ff == `INV60_B) :
                        (hall_ff == `INV120_A || hall_ff == `INV120_B);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_s1_ff <= 3'h0;
      hall_s2_ff <= 3'h0;
      hall_ff    <= 3'h0;
      phase_a_ff <= `PH_OFF;
      phase_b_ff <= `PH_OFF;
      phase_c_ff <= `PH_OFF;
    end else begin
      hall_s1_ff <= hall_in;
      hall_s2_ff <= hall_s1_ff;
      hall_ff    <= hall_s2_ff;
      if (!ctrl_ff[`CTRL_ENABLE] || sine_on || bad_code) begin
        phase_a_ff <= `PH_OFF;
        phase_b_ff <= `PH_OFF;
        phase_c_ff <= `PH_OFF;
      end else begin
        phase_a_ff <= entry[1:0];
        phase_b_ff <= entry[3:2];
        phase_c_ff <= entry[5:4];
      end
    end
  end

  // ****************************************************************
  // sine mode: angle = pos * poles/2, parabolic half-wave sine approximation
  // ****************************************************************
  wire [23:0] eprod = enc_pos * poles_ff[7:1];
  wire [9:0]  ang_a = eprod[15:6];
  wire [9:0]  ang_b = ang_a - `ANG_THIRD;
  wire [9:0]  ang_c = ang_a - `ANG_2THIRD;

  // parabolic sine, cheap; the trade is a few percent harmonic error
  function signed [15:0] psin;
    input [9:0]  ang;
    input [15:0] amp;
    reg   [8:0]  x;
    reg   [17:0] p;
    reg   [31:0] m;
    begin
      x = ang[8:0];
      p = {9'h000, x} * {9'h000, 9'h1FF - x};
      m = {14'h0000, p} * {16'h0000, amp};
      psin = ang[9] ? -$signed({1'b0, m[30:16]}) : $signed({1'b0, m[30:16]});
    end
  endfunction

  wire signed [15:0] va = psin(ang_a, ampl_ff);
  wire signed [15:0] vb = psin(ang_b, ampl_ff);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_a_ff <= 16'h0000;
      sin_b_ff <= 16'h0000;
      sin_c_ff <= 16'h0000;
    end else if (sine_on && ctrl_ff[`CTRL_ENABLE]) begin
      sin_a_ff <= va;
      sin_b_ff <= vb;
      sin_c_ff <= -va - vb;
    end else begin
      sin_a_ff <= 16'h0000;
      sin_b_ff <= 16'h0000;
      sin_c_ff <= 16'h0000;
    end
  end

  // ****************************************************************
  // homing reference select
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      home_ref_ff <= 1'b0;
    else begin
      case (home_sel_ff)
        2'h0:    home_ref_ff <= limit_sw;
        2'h1:    home_ref_ff <= home_sw;
        2'h2:    home_ref_ff <= enc_index;
        default: home_ref_ff <= 1'b0;
      endcase
    end
  end

endmodule

// *** sim/hall_motor_commutator_sva.sv ***
// port checker for the hall commutator
// assumes binding onto the top module, one pclk domain
`timescale 1ns/1ps
module hall_motor_commutator_sva (
  input wire logic        pclk,        // clock
  input wire logic        presetn,     // async reset, low active
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb enable
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic [2:0]  hall_in,     // hall code
  input wire logic        limit_sw,    // limit switch
  input wire logic        home_sw,     // home switch
  input wire logic        enc_index,   // index pulse
  input wire logic [1:0]  phase_a_ff,  // phase a command
  input wire logic [1:0]  phase_b_ff,  // phase b command
  input wire logic [1:0]  phase_c_ff,  // phase c command
  input wire logic [15:0] sin_a_ff,    // sine a
  input wire logic [15:0] sin_b_ff,    // sine b
  input wire logic [15:0] sin_c_ff,    // sine c
  input wire logic        home_ref_ff  // homing reference
);
  // ********
  // properties
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  // table edits come over apb, so quiet means no bus traffic too
  sequence s_quiet; $stable(hall_in) && !psel; endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error w/o ready");
  property p_sum; sin_a_ff + sin_b_ff + sin_c_ff == 16'h0000; endproperty
  a_sum: assert property (p_sum) else $error("sum nonzero");
  property p_pair;
    (|{phase_a_ff, phase_b_ff, phase_c_ff}) |->
      $onehot({phase_a_ff == 2'h1, phase_b_ff == 2'h1, phase_c_ff == 2'h1})
      && $onehot({phase_a_ff == 2'h2, phase_b_ff == 2'h2, phase_c_ff == 2'h2});
  endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
  property p_sync;
    s_quiet [*4] |=> $stable({phase_a_ff, phase_b_ff, phase_c_ff});
  endproperty
  a_sync: assert property (p_sync) else $error("phase moved");
  property p_home; home_ref_ff |-> $past(limit_sw | home_sw | enc_index);
  endproperty
  a_home: assert property (p_home) else $error("home w/o src");
  property p_quiet_err; !pready |-> !pslverr; endproperty
  a_quiet_err: assert property (p_quiet_err) else $error("stray error");
endmodule

// *** sim/hall_encoder_model.sv ***
// hall sensors, encoder and switches standing at the motor side
// assumes requests from the bench; outputs move just after pclk edges
`timescale 1ns/1ps
module hall_encoder_model (
  input  wire logic        pclk,             // clock
  input  wire logic [2:0]  hall_req,         // wanted {h1,h2,h3}
  input  wire logic [15:0] pos_req,          // wanted position
  input  wire logic [2:0]  sw_req,           // {index,home,limit}
  output logic      [2:0]  hall_in = 3'h0,   // hall lines
  output logic      [15:0] enc_pos = 16'h0000, // shaft position
  output logic             limit_sw = 1'b0,  // limit switch
  output logic             home_sw = 1'b0,   // home switch
  output logic             enc_index = 1'b0  // index pulse
);
  always @(posedge pclk) begin
    hall_in <= hall_req;
    enc_pos <= pos_req;
    {enc_index, home_sw, limit_sw} <= sw_req;
  end
endmodule

// *** sim/test_hall_motor_commutator.sv ***
// self-checking bench for the hall commutator
// assumes the design, the sensor model and the checker compiled first
`timescale 1ns/1ps
`include "hall_motor_commutator_consts.vh"
module test_hall_motor_commutator;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, limit_sw, home_sw, enc_index, home_ref_ff;
  logic [2:0] hall_req = 3'h0, sw_req = 3'h0, hall_in;
  logic [15:0] pos_req = 16'h0000, enc_pos, sin_a_ff, sin_b_ff, sin_c_ff;
  logic [15:0] s0, s1;
  logic [1:0] phase_a_ff, phase_b_ff, phase_c_ff;
  int miscompares = 0, checks_done = 0, cycles = 0;
  logic [5:0] t120 [8] = '{6'h00, 6'h18, 6'h06, 6'h12,
                           6'h21, 6'h09, 6'h24, 6'h00};
  logic [5:0] t60 [8] = '{6'h09, 6'h18, 6'h00, 6'h12,
                          6'h21, 6'h00, 6'h24, 6'h06};
  always #5 pclk = ~pclk;
  hall_motor_commutator dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .hall_in, .enc_pos,
    .limit_sw, .home_sw, .enc_index, .phase_a_ff, .phase_b_ff, .phase_c_ff,
    .sin_a_ff, .sin_b_ff, .sin_c_ff, .home_ref_ff);
  hall_encoder_model sensors (.pclk, .hall_req, .pos_req, .sw_req, .hall_in,
    .enc_pos, .limit_sw, .home_sw, .enc_index);
  // ********
  // common tasks
  // ********
  task complete_run;
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task settle; repeat (8) @(posedge pclk); endtask
  task hall(input logic [2:0] c); hall_req <= c; settle; endtask
  // ********
  // scenarios
  // ********
  task t_regs;
    apb(0, `OFS_POLES, 0); chk(rd, 32'h0000_0004);
    apb(0, `OFS_AMPL, 0); chk(rd, 32'h0000_4000);
    for (int c = 0; c < 8; c++) begin
      apb(0, `OFS_SEQ_BASE + 4 * c, 0); chk(rd, t120[c]);
    end
    apb(0, 12'h040, 0); chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    hall(3'h4); chk(phase_a_ff, 2'h0);
  endtask
  task t_table(input logic ph60);
    logic [5:0] want;
    for (int c = 0; c < 8; c++) begin
      want = ph60 ? t60[c] : t120[c];
      hall(c);
      chk({phase_c_ff, phase_b_ff, phase_a_ff}, want);
    end
  endtask
  task t_reprog;
    apb(1, `OFS_SEQ_BASE + 16, `E_CH_BL); hall(3'h0); hall(3'h4);
    chk({phase_c_ff, phase_b_ff, phase_a_ff}, 6'h18);
    // a driving entry under an invalid code must still leave phases off
    apb(1, `OFS_SEQ_BASE + 20, `E_AH_BL); hall(3'h5);
    chk({phase_c_ff, phase_b_ff, phase_a_ff}, 6'h00);
  endtask
  task t_sine;
    apb(1, `OFS_CTRL, 32'h0000_0009); hall(3'h6);
    chk(sin_a_ff, 0);
    chk({phase_c_ff, phase_b_ff, phase_a_ff}, 6'h24);
    apb(1, `OFS_CTRL, 32'h0000_000D);
    apb(0, `OFS_STATUS, 0); chk(rd[0], 1'b1);
    pos_req <= 16'h0800; settle; s0 = sin_a_ff; s1 = -s0;
    // an eighth of a half cycle: near 0.44 of amplitude, loose window
    chk(s0 >= 16'h1400 && s0 <= 16'h2000, 1'b1);
    chk({phase_c_ff, phase_b_ff, phase_a_ff}, 6'h00);
    pos_req <= 16'h8800; settle; chk(sin_a_ff, s0);
    pos_req <= 16'h4800; settle; chk(sin_a_ff, s1);
    // a third of a cycle later, phase b shows what phase a showed
    pos_req <= 16'h32A0; settle; chk(sin_b_ff, s0);
  endtask
  task t_home;
    apb(1, `OFS_HOME_SEL, 1); sw_req <= 3'h2; settle;
    chk(home_ref_ff, 1);
    apb(1, `OFS_HOME_SEL, 0); settle; chk(home_ref_ff, 0);
    apb(1, `OFS_HOME_SEL, 2); sw_req <= 3'h4; settle;
    chk(home_ref_ff, 1);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_regs;
    apb(1, `OFS_CTRL, 32'h0000_0008); t_table(1'b0);
    apb(1, `OFS_CTRL, 32'h0000_000A); t_table(1'b1);
    t_reprog;
    t_sine;
    t_home;
    complete_run;
  end
endmodule
bind hall_motor_commutator hall_motor_commutator_sva u_sva (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .hall_in, .limit_sw, .home_sw,
  .enc_index, .phase_a_ff, .phase_b_ff, .phase_c_ff, .sin_a_ff, .sin_b_ff,
  .sin_c_ff, .home_ref_ff);
